// File: hdl/parallel_move_decode.sv
// parallel move decode and execute unit with wishbone register access
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Operation
// RULE1 - class one moves an x memory word and copies an accumulator to y input
// RULE2 - class one takes every addressing mode, absolute and immediate included; the offset-register modes are refused here
// RULE3 - copied accumulator is in place before the next instruction starts
// RULE4 - class two stores an accumulator and reloads it from x0, one address
// RULE5 - class two refuses long absolute and long immediate modes
// RULE6 - software never loads the accumulator that the arithmetic writes
// RULE7 - arithmetic sources may also be move sources, both moves the same
// RULE8 - moves change only scaling and limit flags of the condition register
// RULE9 - bit 15 is direction, bits 13..8 address field, 7..0 arithmetic opcode
// RULE10 - class one register field picks x0, x1, a or b; extension optional
// RULE11 - one bit picks copy source accumulator, one bit picks y0 or y1
// RULE12 - class two holds address field and one accumulator select bit
// RULE13 - y memory move takes any mode: absolute, immediate, short absolute; the offset-register modes are refused here
// RULE14 - standalone y moves address register plus short or long offset
// RULE15 - software never loads the arithmetic destination in a y move
// RULE16 - an arithmetic source may also be the y store source
// RULE17 - storing an accumulator with extension in use writes a saturation word
// RULE18 - move sources are read before the arithmetic result lands
// RULE19 - load destination overlapping arithmetic destination is flagged illegal
// ----------------------------------------------------------------
module parallel_move_decode
  import pmove_pkg::*;
(
  input  wire logic        clk_i,     // core clock
  input  wire logic        rst_i,     // sync reset, high
  input  wire logic        wb_cyc_i,  // bus cycle
  input  wire logic        wb_stb_i,  // strobe
  input  wire logic        wb_we_i,   // write
  input  wire logic [7:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte lanes
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic [31:0]      wb_dat_o,  // read data
  output logic             wb_ack_o,  // acknowledge
  output logic             busy_o,    // executing a word
  output logic             bad_o      // last word refused
);
  pm_s s_ff;
  pm_s nxt_s;
  logic [23:0] i;
  kind_e kind;
  logic [2:0]  mode;
  logic [2:0]  rrr;
  logic [4:0]  rcode;
  logic [4:0]  csrc;
  logic [4:0]  cdst;
  logic [15:0] disp;
  logic        mrd, ymem, rel, cpy, ok, conflict, alu_on;
  logic [15:0] ea_addr;
  logic        ea_imm, ea_bad;
  rfile_t      regs;
  logic [15:0] ld;
  logic        wr_ok, sw_r, rwe;
  logic [2:0]  ridx;
  logic [15:0] rval;
  logic [5:0]  off;

  mem_if xm ();
  mem_if ym ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic ext_used(input logic [39:0] acc);
    return !((&acc[39:31]) || !(|acc[39:31]));
  endfunction

  function automatic logic [15:0] lim(input logic [39:0] acc);
    if (ext_used(acc))
      return acc[39] ? `SAT_NEG : `SAT_POS;
    return acc[31:16];
  endfunction

  function automatic logic [7:0] flg(input logic [39:0] acc);
    logic [7:0] f;
    f = 8'h00;
    f[`CCR_S] = acc[31] ^ acc[30];
    f[`CCR_L] = ext_used(acc);
    return f;
  endfunction

  function automatic logic full_acc(input logic [4:0] c);
    return (c == `RC_A) || (c == `RC_B);
  endfunction

  function automatic logic is_part(input logic [4:0] c, input logic acc);
    return (c >= `RC_A0) && (c <= `RC_B) && (c[0] == acc);
  endfunction

  function automatic logic [15:0] reg_read(input pm_s s, input logic [4:0] c, input rfile_t r);
    logic [39:0] acc;
    acc = c[0] ? s.b : s.a;
    case (c)
      `RC_X0: return s.x0;
      `RC_X1: return s.x1;
      `RC_Y0: return s.y0;
      `RC_Y1: return s.y1;
      `RC_A0, `RC_B0: return acc[15:0];
      `RC_A2, `RC_B2: return {{8{acc[39]}}, acc[39:32]};
      `RC_A1, `RC_B1: return acc[31:16];
      `RC_A, `RC_B: return lim(acc); // RULE17
      default: return r[c[2:0]];
    endcase
  endfunction

  function automatic pm_s wr_reg(input pm_s s, input logic [4:0] c, input logic [15:0] v);
    pm_s t;
    logic [39:0] acc;
    t = s;
    acc = c[0] ? s.b : s.a;
    case (c)
      `RC_X0: t.x0 = v;
      `RC_X1: t.x1 = v;
      `RC_Y0: t.y0 = v;
      `RC_Y1: t.y1 = v;
      `RC_A0, `RC_B0: acc[15:0] = v;
      `RC_A2, `RC_B2: acc[39:32] = v[7:0];
      `RC_A1, `RC_B1: acc[31:16] = v;
      `RC_A, `RC_B: acc = {{8{v[15]}}, v, 16'h0000};
      default: ;
    endcase
    if (is_part(c, 1'b1))
      t.b = acc;
    else if (is_part(c, 1'b0))
      t.a = acc;
    return t;
  endfunction

  function automatic logic [31:0] wmrg(input logic [31:0] old);
    logic [31:0] v;
    v = old;
    for (int k = 0; k < 4; k++) begin
      if (wb_sel_i[k])
        v[8*k +: 8] = wb_dat_i[8*k +: 8];
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // instruction word decode
  // ----------------------------------------------------------------
  assign i = s_ff.insn;

  always_comb begin
    kind = K_BAD;
    mode = i[13:11]; // RULE9
    rrr = i[10:8];
    mrd = i[15]; // RULE9
    rcode = `RC_X0;
    csrc = `RC_A;
    cdst = `RC_Y0;
    cpy = 1'b0;
    rel = 1'b0;
    ymem = 1'b0;
    disp = 16'h0000;
    if (i[23:20] == 4'b0001 && !i[14]) begin
      kind = K_XR1; // RULE1
      rcode = i[19] ? (i[18] ? `RC_B : `RC_A) : (i[18] ? `RC_X1 : `RC_X0); // RULE10
      cpy = 1'b1;
      csrc = i[17] ? `RC_B : `RC_A; // RULE11
      cdst = i[16] ? `RC_Y1 : `RC_Y0; // RULE11
    end else if (i[23:17] == 7'b0000100 && i[15:14] == 2'b00) begin
      kind = K_XR2; // RULE12
      mrd = 1'b0;
      rcode = i[16] ? `RC_B : `RC_A; // RULE4
      cpy = 1'b1;
      csrc = `RC_X0;
      cdst = rcode;
    end else if (i[23:22] == 2'b01 && i[19]) begin
      kind = i[14] ? K_YEA : K_YAA; // RULE13
      rcode = {i[21:20], i[18:16]};
      ymem = 1'b1;
    end else if (i[23:11] == {8'h0b, 5'b01110} && i[7]) begin
      kind = K_YRL; // RULE14
      rel = 1'b1;
      ymem = 1'b1;
      disp = s_ff.ext;
      mrd = i[6];
      rcode = i[4:0];
    end else if (i[23:17] == 7'b0000001 && i[7] && i[5]) begin
      kind = K_YRS; // RULE14
      rel = 1'b1;
      ymem = 1'b1;
      disp = {{9{i[16]}}, i[16:11], i[6]};
      mrd = i[4];
      rcode = {1'b0, i[3:0]};
    end
    alu_on = s_ff.alu_en && !rel;
    conflict = alu_on && (mrd || kind == K_XR2) && is_part(rcode, s_ff.alu_acc); // RULE19 RULE6 RULE15
    ok = (kind != K_BAD) && (rcode < 5'h0c || rcode[4:3] == 2'b10)
         && !(kind == K_YRL && i[5])
         && !(ea_bad && kind != K_YAA && !rel) // RULE2 RULE13
         && !(kind == K_XR2 && mode == `EA_ABS) // RULE5
         && !(ea_imm && !mrd) && !conflict;
  end

  ea_gen u_ea (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .mode_i (kind == K_YAA ? `EA_RN : mode),
    .rrr_i  (rrr),
    .ext_i  (s_ff.ext),
    .disp_i (disp),
    .rel_i  (rel),
    .upd_i  (s_ff.st == ST_MEM),
    .we_i   (rwe),
    .widx_i (ridx),
    .wval_i (rval),
    .addr_o (ea_addr),
    .imm_o  (ea_imm),
    .bad_o  (ea_bad),
    .regs_o (regs)
  );

  // ----------------------------------------------------------------
  // memory ports
  // ----------------------------------------------------------------
  assign xm.req = (s_ff.st == ST_MEM) && !ymem && !ea_imm;
  assign xm.we = !mrd;
  assign xm.addr = s_ff.addr;
  assign xm.wdata = s_ff.sval;
  assign ym.req = (s_ff.st == ST_MEM) && ymem && !ea_imm;
  assign ym.we = !mrd;
  assign ym.addr = s_ff.addr;
  assign ym.wdata = s_ff.sval;

  data_mem u_xmem (.clk_i(clk_i), .rst_i(rst_i), .port(xm));
  data_mem u_ymem (.clk_i(clk_i), .rst_i(rst_i), .port(ym));

  assign ld = ea_imm ? s_ff.ext : (ymem ? ym.rdata : xm.rdata); // RULE2
  assign off = wb_adr_i[7:2];
  assign wr_ok = wb_cyc_i && wb_stb_i && !s_ff.ack && wb_we_i && !s_ff.busy;
  assign sw_r = wr_ok && off[5:3] == `OFF_RHI;
  assign rwe = sw_r || (s_ff.st == ST_WB && mrd && rcode[4]);
  assign ridx = sw_r ? off[2:0] : rcode[2:0];
  assign rval = sw_r ? 16'(wmrg({16'h0000, regs[off[2:0]]})) : ld;

  // ----------------------------------------------------------------
  // sequencer and register file
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = 1'b0;
    case (s_ff.st)
      ST_IDLE: ;
      ST_DEC: begin
        // snapshot sources now so the arithmetic write cannot leak in
        nxt_s.sval = reg_read(s_ff, rcode, regs); // RULE18 RULE7 RULE16
        nxt_s.cval = reg_read(s_ff, csrc, regs); // RULE18 RULE7
        nxt_s.addr = (kind == K_YAA) ? {2'b00, i[13:8]} : ea_addr[`MEM_AW-1:0];
        nxt_s.fl = 8'h00;
        if (!mrd && full_acc(rcode))
          nxt_s.fl = flg(rcode[0] ? s_ff.b : s_ff.a); // RULE8
        if (cpy && full_acc(csrc))
          nxt_s.fl = nxt_s.fl | flg(csrc[0] ? s_ff.b : s_ff.a); // RULE8
        if (ok) begin
          nxt_s.st = ST_MEM;
        end else begin
          nxt_s.bad = 1'b1; // RULE19
          nxt_s.busy = 1'b0;
          nxt_s.st = ST_IDLE;
        end
      end
      ST_MEM: nxt_s.st = ST_WB;
      ST_WB: begin
        if (alu_on) begin
          if (s_ff.alu_acc)
            nxt_s.b = {{8{s_ff.aluv[31]}}, s_ff.aluv};
          else
            nxt_s.a = {{8{s_ff.aluv[31]}}, s_ff.aluv};
        end
        if (cpy)
          nxt_s = wr_reg(nxt_s, cdst, s_ff.cval); // RULE1 RULE3 RULE4
        if (mrd && !rcode[4])
          nxt_s = wr_reg(nxt_s, rcode, ld); // RULE13
        nxt_s.condition_flags_reg = s_ff.condition_flags_reg | s_ff.fl; // RULE8
        nxt_s.done = 1'b1;
        nxt_s.busy = 1'b0;
        nxt_s.st = ST_IDLE;
      end
      default: nxt_s.st = ST_IDLE;
    endcase
    if (wb_cyc_i && wb_stb_i && !s_ff.ack) begin
      nxt_s.ack = 1'b1;
      case (off)
        `OFF_INSN: nxt_s.dat = {8'h00, s_ff.insn};
        `OFF_EXT: nxt_s.dat = {16'h0000, s_ff.ext};
        `OFF_ALUV: nxt_s.dat = s_ff.aluv;
        `OFF_CTRL: nxt_s.dat = {29'h0, s_ff.alu_acc, s_ff.alu_en, 1'b0};
        `OFF_STAT: nxt_s.dat = {29'h0, s_ff.bad, s_ff.done, s_ff.busy};
        `OFF_CCR: nxt_s.dat = {24'h0, s_ff.condition_flags_reg};
        `OFF_X0: nxt_s.dat = {16'h0000, s_ff.x0};
        `OFF_X1: nxt_s.dat = {16'h0000, s_ff.x1};
        `OFF_Y0: nxt_s.dat = {16'h0000, s_ff.y0};
        `OFF_Y1: nxt_s.dat = {16'h0000, s_ff.y1};
        `OFF_AL: nxt_s.dat = s_ff.a[31:0];
        `OFF_AH: nxt_s.dat = {24'h0, s_ff.a[39:32]};
        `OFF_BL: nxt_s.dat = s_ff.b[31:0];
        `OFF_BH: nxt_s.dat = {24'h0, s_ff.b[39:32]};
        default: nxt_s.dat = (off[5:3] == `OFF_RHI) ? {16'h0000, regs[off[2:0]]} : 32'h0;
      endcase
    end
    // writes are refused while a word executes so operands stay stable
    if (wr_ok) begin
      case (off)
        `OFF_INSN: nxt_s.insn = 24'(wmrg({8'h00, s_ff.insn}));
        `OFF_EXT: nxt_s.ext = 16'(wmrg({16'h0000, s_ff.ext}));
        `OFF_ALUV: nxt_s.aluv = wmrg(s_ff.aluv);
        `OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            nxt_s.alu_en = wb_dat_i[`CTRL_ALU];
            nxt_s.alu_acc = wb_dat_i[`CTRL_ACC];
            if (wb_dat_i[`CTRL_GO]) begin
              nxt_s.st = ST_DEC;
              nxt_s.busy = 1'b1;
              nxt_s.done = 1'b0;
              nxt_s.bad = 1'b0;
            end
          end
        end
        `OFF_CCR: nxt_s.condition_flags_reg = 8'(wmrg({24'h0, s_ff.condition_flags_reg}));
        `OFF_X0: nxt_s.x0 = 16'(wmrg({16'h0000, s_ff.x0}));
        `OFF_X1: nxt_s.x1 = 16'(wmrg({16'h0000, s_ff.x1}));
        `OFF_Y0: nxt_s.y0 = 16'(wmrg({16'h0000, s_ff.y0}));
        `OFF_Y1: nxt_s.y1 = 16'(wmrg({16'h0000, s_ff.y1}));
        `OFF_AL: nxt_s.a[31:0] = wmrg(s_ff.a[31:0]);
        `OFF_AH: nxt_s.a[39:32] = 8'(wmrg({24'h0, s_ff.a[39:32]}));
        `OFF_BL: nxt_s.b[31:0] = wmrg(s_ff.b[31:0]);
        `OFF_BH: nxt_s.b[39:32] = 8'(wmrg({24'h0, s_ff.b[39:32]}));
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.condition_flags_reg <= `CCR_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_dat_o = s_ff.dat;
  assign wb_ack_o = s_ff.ack;
  assign busy_o = s_ff.busy;
  assign bad_o = s_ff.bad;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run;
    (s_ff.st == ST_MEM) ##1 (s_ff.st == ST_WB);
  endsequence

  AST_COPY_NEXT: assert property ((s_ff.st == ST_DEC) && ok && kind == K_XR1 |=> s_run ##1 // RULE3
    ((i[16] ? s_ff.y1 : s_ff.y0) == s_ff.cval) && s_ff.done) else $error("copy not in place");
  AST_DIR: assert property ((s_ff.st == ST_MEM) && kind == K_XR1 && !ea_imm |-> // RULE9
    xm.req && (xm.we == !i[15])) else $error("x direction wrong");
  AST_CLASS2: assert property ((s_ff.st == ST_MEM) && kind == K_XR2 |-> xm.req && xm.we ##1 1'b1 ##1 // RULE4
    ((i[16] ? s_ff.b[31:16] : s_ff.a[31:16]) == s_ff.cval)) else $error("class two wrong");
  AST_NO_LONG: assert property ((s_ff.st == ST_DEC) && kind == K_XR2 && mode == `EA_ABS |=> // RULE5
    s_ff.bad && (s_ff.st == ST_IDLE)) else $error("long mode accepted");
  AST_OVERLAP: assert property ((s_ff.st == ST_DEC) && conflict |=> // RULE19
    s_ff.bad && !s_ff.busy && (s_ff.st == ST_IDLE)) else $error("overlap not flagged");
  AST_CCR: assert property ((s_ff.st == ST_WB) |=> (s_ff.condition_flags_reg[5:0] == $past(s_ff.condition_flags_reg[5:0])) // RULE8
    && (s_ff.condition_flags_reg[7:6] == ($past(s_ff.condition_flags_reg[7:6]) | $past(s_ff.fl[7:6])))) else $error("flags wrong");
  AST_SAT: assert property (ym.req && ym.we && rcode == `RC_A && ext_used(s_ff.a) |-> // RULE17
    ym.wdata == (s_ff.a[39] ? `SAT_NEG : `SAT_POS)) else $error("no saturation");
  AST_YREL: assert property ((s_ff.st == ST_MEM) && rel && !ea_imm |-> // RULE14
    ym.req && (ym.addr == `MEM_AW'(regs[rrr] + disp))) else $error("relative address wrong");
  AST_IMM: assert property ((s_ff.st == ST_WB) && ea_imm && rcode == `RC_X0 && kind == K_XR1 |=> // RULE2
    s_ff.x0 == $past(s_ff.ext)) else $error("immediate not loaded");
  AST_ACK: assert property (s_ff.ack |=> !s_ff.ack) else $error("ack longer than one cycle");
endmodule

// File: hdl/pmove_params.svh
// offsets, field positions, reset values and codes for the parallel move unit
`ifndef PMOVE_PARAMS_SVH
`define PMOVE_PARAMS_SVH
`define OFF_INSN 6'h00
`define OFF_EXT  6'h01
`define OFF_ALUV 6'h02
`define OFF_CTRL 6'h03
`define OFF_STAT 6'h04
`define OFF_CCR  6'h05
`define OFF_X0   6'h06
`define OFF_X1   6'h07
`define OFF_Y0   6'h08
`define OFF_Y1   6'h09
`define OFF_AL   6'h0a
`define OFF_AH   6'h0b
`define OFF_BL   6'h0c
`define OFF_BH   6'h0d
`define OFF_RHI  3'b010
`define CTRL_GO  0
`define CTRL_ALU 1
`define CTRL_ACC 2
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_BAD  2
`define CCR_S    7
`define CCR_L    6
`define CCR_RST  8'h00
`define SAT_POS  16'h7fff
`define SAT_NEG  16'h8000
`define RC_X0 5'h00
`define RC_X1 5'h01
`define RC_Y0 5'h02
`define RC_Y1 5'h03
`define RC_A0 5'h04
`define RC_B0 5'h05
`define RC_A2 5'h06
`define RC_B2 5'h07
`define RC_A1 5'h08
`define RC_B1 5'h09
`define RC_A  5'h0a
`define RC_B  5'h0b
`define EA_PDEC  3'b010
`define EA_PINC  3'b011
`define EA_RN    3'b100
`define EA_ABS   3'b110
`define EA_PRED  3'b111
`define RRR_ABS  3'b000
`define RRR_IMM  3'b100
`define MEM_AW   8
`endif

// File: hdl/pmove_pkg.sv
// types shared by the parallel move unit
`include "pmove_params.svh"
package pmove_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_DEC = 2'b01, ST_MEM = 2'b11, ST_WB = 2'b10} st_e;
  typedef enum logic [2:0] {K_BAD, K_XR1, K_XR2, K_YEA, K_YAA, K_YRL, K_YRS} kind_e;
  typedef logic [7:0][15:0] rfile_t;
  typedef struct packed {
    st_e         st;
    logic [23:0] insn;
    logic [15:0] ext;
    logic [31:0] aluv;
    logic        alu_en;
    logic        alu_acc;
    logic        busy;
    logic        done;
    logic        bad;
    logic [7:0]  condition_flags_reg;
    logic [15:0] x0, x1, y0, y1;
    logic [39:0] a, b;
    logic        ack;
    logic [31:0] dat;
    logic [`MEM_AW-1:0] addr;
    logic [15:0] sval;
    logic [15:0] cval;
    logic [7:0]  fl;
  } pm_s;
  typedef struct packed {
    rfile_t r;
  } ea_s;
  typedef struct packed {
    logic [2**`MEM_AW-1:0][15:0] m;
    logic [15:0] rd;
  } mem_s;
endpackage

// File: hdl/mem_if.sv
// access port between the move unit and one data memory
`timescale 1ns/10ps
`include "pmove_params.svh"
interface mem_if;
  logic              req;
  logic              we;
  logic [`MEM_AW-1:0] addr;
  logic [15:0]       wdata;
  logic [15:0]       rdata;
  modport ctl (output req, we, addr, wdata, input rdata);
  modport mem (input req, we, addr, wdata, output rdata);
endinterface

// File: hdl/data_mem.sv
// one word-wide data memory with registered read data
`timescale 1ns/10ps
module data_mem
  import pmove_pkg::*;
(
  input  wire logic clk_i,  // core clock
  input  wire logic rst_i,  // sync reset, high
  mem_if.mem        port    // access port
);
  mem_s s_ff;
  mem_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (port.req) begin
      if (port.we)
        nxt_s.m[port.addr] = port.wdata;
      else
        nxt_s.rd = s_ff.m[port.addr];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign port.rdata = s_ff.rd;
endmodule

// File: hdl/ea_gen.sv
// address registers and effective address arithmetic
`timescale 1ns/10ps
module ea_gen
  import pmove_pkg::*;
(
  input  wire logic        clk_i,   // core clock
  input  wire logic        rst_i,   // sync reset, high
  input  wire logic [2:0]  mode_i,  // addressing mode
  input  wire logic [2:0]  rrr_i,   // address register
  input  wire logic [15:0] ext_i,   // extension word
  input  wire logic [15:0] disp_i,  // relative displacement
  input  wire logic        rel_i,   // register plus displacement
  input  wire logic        upd_i,   // apply post/pre modify
  input  wire logic        we_i,    // direct register write
  input  wire logic [2:0]  widx_i,  // write index
  input  wire logic [15:0] wval_i,  // write value
  output logic [15:0]      addr_o,  // effective address
  output logic             imm_o,   // immediate operand
  output logic             bad_o,   // unsupported mode
  output rfile_t           regs_o   // register contents
);
  ea_s s_ff;
  ea_s nxt_s;
  logic [15:0] r;

  always_comb begin
    nxt_s = s_ff;
    r = s_ff.r[rrr_i];
    addr_o = r;
    imm_o = 1'b0;
    bad_o = 1'b0;
    if (rel_i) begin
      addr_o = r + disp_i;
    end else begin
      case (mode_i)
        `EA_RN, `EA_PINC, `EA_PDEC: addr_o = r;
        `EA_PRED: addr_o = r - 16'h0001;
        `EA_ABS: begin
          addr_o = ext_i;
          imm_o = (rrr_i == `RRR_IMM);
          bad_o = (rrr_i != `RRR_IMM) && (rrr_i != `RRR_ABS);
        end
        // offset-register modes have no offset registers here
        default: bad_o = 1'b1;
      endcase
      if (upd_i) begin
        case (mode_i)
          `EA_PINC: nxt_s.r[rrr_i] = r + 16'h0001;
          `EA_PDEC, `EA_PRED: nxt_s.r[rrr_i] = r - 16'h0001;
          default: ;
        endcase
      end
    end
    if (we_i)
      nxt_s.r[widx_i] = wval_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign regs_o = s_ff.r;
endmodule

// File: verification/wb_host.sv
// wishbone host model that stands in for software on the register bus
`timescale 1ns/10ps
module wb_host (
  input  wire logic        clk_i,  // core clock
  input  wire logic        ack_i,  // acknowledge from the unit
  input  wire logic [31:0] dat_i,  // read data from the unit
  output logic             cyc_o,  // bus cycle
  output logic             stb_o,  // strobe
  output logic             we_o,   // write
  output logic [7:0]       adr_o,  // byte address
  output logic [3:0]       sel_o,  // byte lanes
  output logic [31:0]      dat_o   // write data
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // ----------------------------------------------------------------
  // single classic cycle
  // ----------------------------------------------------------------
  // the request stands until ack is seen; released we, address and data lines show the inverse so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= ~w;
    adr_o <= ~a;
    dat_o <= ~d;
    // the next call waits one edge first, so cyc stays low for one cycle between requests
  endtask
endmodule

// File: verification/parallel_move_decode_test.sv
// self-checking bench for the parallel move unit over its register bus
`timescale 1ns/10ps
`include "pmove_params.svh"
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module parallel_move_decode_test;
  logic        clk_i;
  logic        rst_i;
  logic        cyc, stb, we, ack, busy_o, bad_o;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, st;
  logic [15:0] sat;
  int          num_errors = 0;
  int          checked = 0;

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  parallel_move_decode u_parallel_move_decode (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .busy_o(busy_o), .bad_o(bad_o));
  wb_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [5:0] o, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, {o, 2'b00}, d, q);
  endtask

  task automatic rd(input logic [5:0] o, output logic [31:0] q);
    host.xfer(1'b0, {o, 2'b00}, 32'h0, q);
  endtask

  task automatic expect_reg(input string nm, input logic [5:0] o, input logic [31:0] e);
    logic [31:0] q;
    rd(o, q);
    `CHK(nm, e, q)
  endtask

  // poke only on legal words: a refused word frees the unit before the poke lands
  task automatic exec(input logic [23:0] insn, input logic [15:0] ext, input logic [1:0] alu, input logic poke,
                      output logic [31:0] s);
    int n;
    wr(`OFF_INSN, {8'h00, insn});
    wr(`OFF_EXT, {16'h0000, ext});
    wr(`OFF_CTRL, {29'h0, alu, 1'b1});
    if (poke) begin
      wr(`OFF_CCR, 32'h0000_00ff);
    end
    n = 0;
    s = 32'h1;
    while (s[`STAT_BUSY] !== 1'b0 && n < 20) begin
      rd(`OFF_STAT, s);
      n++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    expect_reg("flags", `OFF_CCR, {24'h0, `CCR_RST});
    wr(6'h0e, 32'hffff_ffff);
    expect_reg("unmapped", 6'h0e, 32'h0);
    $display("test reset done");
    wr(`OFF_AL, 32'h1234_0000);
    wr(`OFF_AH, 32'h0);
    exec(24'h11b400, 16'h5a5a, 2'b00, 1'b1, st);
    `CHK("status", 3'b010, st[2:0])
    `CHK("busy_o idle", 1'b0, busy_o)
    expect_reg("x0 imm", `OFF_X0, 32'h5a5a);
    expect_reg("y1 copy", `OFF_Y1, 32'h1234);
    expect_reg("flags busy", `OFF_CCR, 32'h0);
    $display("test class one done");
    wr(6'h10, 32'h10);
    exec(24'h082000, 16'h0, 2'b00, 1'b1, st);
    expect_reg("a low", `OFF_AL, 32'h5a5a_0000);
    exec(24'h16a000, 16'h0, 2'b00, 1'b1, st);
    expect_reg("x1 mem", `OFF_X1, 32'h1234);
    expect_reg("y0 copy", `OFF_Y0, 32'h0);
    for (int i = 0; i < 2; i++) begin
      exec(i ? 24'h083400 : 24'h083000, 16'h1234, 2'b00, 1'b0, st);
      `CHK("bad status", 1'b1, st[`STAT_BAD])
      `CHK("bad_o", 1'b1, bad_o)
    end
    $display("test class two done");
    exec(24'h18b400, 16'h1111, 2'b01, 1'b0, st);
    `CHK("overlap", 1'b1, st[`STAT_BAD])
    expect_reg("a kept", `OFF_AL, 32'h5a5a_0000);
    wr(`OFF_BL, 32'h0022_0000);
    wr(`OFF_ALUV, 32'h0077_0000);
    exec(24'h163000, 16'h0020, 2'b11, 1'b1, st);
    `CHK("bad_o clear", 1'b0, bad_o)
    expect_reg("y0 old b", `OFF_Y0, 32'h0022);
    expect_reg("b result", `OFF_BL, 32'h0077_0000);
    $display("test overlap done");
    wr(`OFF_CCR, 32'h05);
    for (int i = 0; i < 2; i++) begin
      wr(`OFF_AL, 32'h0);
      wr(`OFF_AH, i ? 32'hfe : 32'h01);
      sat = i ? `SAT_NEG : `SAT_POS;
      exec(24'h183000, 16'h0030, 2'b00, 1'b1, st);
      expect_reg("y0 sat", `OFF_Y0, {16'h0, sat});
      exec(24'h10b000, 16'h0030, 2'b00, 1'b1, st);
      expect_reg("x mem sat", `OFF_X0, {16'h0, sat});
    end
    exec(24'h5a7000, 16'h0050, 2'b00, 1'b1, st);
    exec(24'h0b70c3, 16'h0040, 2'b00, 1'b1, st);
    expect_reg("y store sat", `OFF_Y1, {16'h0, `SAT_NEG});
    expect_reg("flags sat", `OFF_CCR, 32'h45);
    $display("test saturation done");
    exec(24'h48f400, 16'hbeef, 2'b00, 1'b1, st);
    expect_reg("y imm", `OFF_X0, 32'hbeef);
    exec(24'h487000, 16'h0040, 2'b00, 1'b1, st);
    exec(24'h0b70c3, 16'h0030, 2'b00, 1'b1, st);
    expect_reg("y disp", `OFF_Y1, 32'hbeef);
    $display("test y move done");
    wrap_up();
  end
endmodule
